// ==== tx_byte_serializer_8b10b_encoder.sv ====
// transmit byte serializer with optional 8b/10b line encoder and axi4-lite control
// How it works
// - in double width a 32-bit word goes out as bits 15:0 first, then bits 31:16.
// - double width halves the word, 32 bits into two 16-bit and 40 bits into two 20-bit outputs.
// - single width sends the low byte first, then the high byte, 16 into 8 or 20 into 10 bits.
// - with encoding enabled the halves pass through the encoder, otherwise they go out raw.
// - the encoder only operates when the channel is set to the pci express protocol.
// - each byte plus its control flag becomes one 10-bit group chosen by running disparity.
// - a flagged byte yields its Kx.y group, an unflagged byte its Dx.y group.
// - bit 0 of every 10-bit group is the first bit on the serial line.
// - byte bc with the control flag set is sent as the K28.5 comma.
// - the transmit reset clears running disparity and the data registers.
// - while reset is held the output is the negative K28.5 group regardless of inputs.
// - during reset the fabric data and control flags are ignored.
// - after reset the encoder starts negative and sends three K28.5 before user data.
// - the first user data follows directly after the third sync group.
`timescale 1ns/1ns
module tx_byte_serializer_8b10b_encoder
   import tx_serenc_pkg::*;
#(
   parameter int LANES = 4
) (
   input wire logic clk,
   input wire logic resetn,
   // fabric side, word is taken at an edge where txReady is high
   input wire logic [LANES*LANE_W-1:0] txData,
   input wire logic [LANES-1:0] txDataK,
   output logic txReady,
   // toward the serializer, lane 0 in bits 9:0
   output logic [2*LANE_W-1:0] txCode,
   // axi4-lite slave
   input wire logic [tx_serenc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [tx_serenc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import tx_serenc_pkg::*;

   // one 8b/10b group: returns {running disparity after, code}, bit 0 sent first
   function automatic logic [LANE_W:0] encode(input logic [7:0] b, input logic k,
                                              input logic rd);
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] l6;
      logic [3:0] l4;
      logic k28;
      logic unbal6;
      logic unbal4;
      logic rd6;
      logic alt;
      logic [LANE_W-1:0] code;
      x = b[4:0];
      y = b[7:5];
      k28 = k && (x == K28_X);
      // 6-bit sub-block, written abcdei with a leftmost, negative column
      unique case (x)
         5'h00: l6 = 6'h27; 5'h01: l6 = 6'h1d; 5'h02: l6 = 6'h2d; 5'h03: l6 = 6'h31;
         5'h04: l6 = 6'h35; 5'h05: l6 = 6'h29; 5'h06: l6 = 6'h19; 5'h07: l6 = 6'h38;
         5'h08: l6 = 6'h39; 5'h09: l6 = 6'h25; 5'h0a: l6 = 6'h15; 5'h0b: l6 = 6'h34;
         5'h0c: l6 = 6'h0d; 5'h0d: l6 = 6'h2c; 5'h0e: l6 = 6'h1c; 5'h0f: l6 = 6'h17;
         5'h10: l6 = 6'h1b; 5'h11: l6 = 6'h23; 5'h12: l6 = 6'h13; 5'h13: l6 = 6'h32;
         5'h14: l6 = 6'h0b; 5'h15: l6 = 6'h2a; 5'h16: l6 = 6'h1a; 5'h17: l6 = 6'h3a;
         5'h18: l6 = 6'h33; 5'h19: l6 = 6'h26; 5'h1a: l6 = 6'h16; 5'h1b: l6 = 6'h36;
         5'h1c: l6 = 6'h0e; 5'h1d: l6 = 6'h2e; 5'h1e: l6 = 6'h1e; default: l6 = 6'h2b;
      endcase
      if (k28) begin
         l6 = 6'h0f;
      end
      unbal6 = ($countones(l6) != 3);
      // positive column is the complement for unbalanced codes and for the d7 pair
      if (rd && (unbal6 || (x == 5'h07 && !k28))) begin
         l6 = ~l6;
      end
      rd6 = rd ^ unbal6;
      if (k28) begin
         // table for a positive disparity after the 6-bit block
         unique case (y)
            3'h0: l4 = 4'h4; 3'h1: l4 = 4'h9; 3'h2: l4 = 4'h5; 3'h3: l4 = 4'h3;
            3'h4: l4 = 4'h2; 3'h5: l4 = 4'ha; 3'h6: l4 = 4'h6; default: l4 = 4'h8;
         endcase
         if (!rd6) begin
            l4 = ~l4;
         end
      end else begin
         // alternate x.7 avoids a run of five, and is the only form for other k codes
         alt = (y == 3'h7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
               || (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
         unique case (y)
            3'h0: l4 = 4'hb; 3'h1: l4 = 4'h9; 3'h2: l4 = 4'h5; 3'h3: l4 = 4'hc;
            3'h4: l4 = 4'hd; 3'h5: l4 = 4'ha; 3'h6: l4 = 4'h6; default: l4 = 4'he;
         endcase
         if (alt) begin
            l4 = 4'h7;
         end
         if (rd6 && (($countones(l4) != 2) || y == 3'h3)) begin
            l4 = ~l4;
         end
      end
      unbal4 = ($countones(l4) != 2);
      // a goes to bit 0 so the line sees abcdei fghj in order
      for (int i = 0; i < 6; i++) begin
         code[i] = l6[5-i];
      end
      for (int i = 0; i < 4; i++) begin
         code[6+i] = l4[3-i];
      end
      encode = {rd6 ^ unbal4, code};
   endfunction

   // fabric word split into 10-bit lanes, 8-bit mode zero-extends each byte
   logic [LANE_W-1:0] laneIn [LANES];
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic wide10;
   logic dbl;
   logic encOn;

   assign wide10 = ctrl_q[CTRL_WIDE10_BIT];
   assign dbl = ctrl_q[CTRL_DOUBLE_BIT];
   assign encOn = ctrl_q[CTRL_ENC_BIT] & ctrl_q[CTRL_PCIE_BIT];

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gLane
         assign laneIn[g] = wide10 ? txData[g*LANE_W +: LANE_W]
                                   : {2'h0, txData[g*BYTE_W +: BYTE_W]};
      end
   endgenerate

   // datapath state
   logic phase_q, phase_d;
   logic ready_q, ready_d;
   logic rd_q, rd_d;
   logic [1:0] syncCnt_q, syncCnt_d;
   logic [LANE_W-1:0] hold_q [2];
   logic [LANE_W-1:0] hold_d [2];
   logic [1:0] holdK_q, holdK_d;
   logic [2*LANE_W-1:0] code_q, code_d;
   logic running;

   // encoding holds off the fabric until the comma preamble is out
   assign running = !(encOn && syncCnt_q != SYNC_GROUPS);

   // serializer and encoder next state
   always_comb begin
      logic [LANE_W-1:0] sA;
      logic [LANE_W-1:0] sB;
      logic kA;
      logic kB;
      logic [LANE_W:0] eA;
      logic [LANE_W:0] eB;
      sA = '0;
      sB = '0;
      kA = 1'b0;
      kB = 1'b0;
      eA = '0;
      eB = '0;
      phase_d = phase_q;
      rd_d = rd_q;
      syncCnt_d = syncCnt_q;
      hold_d = hold_q;
      holdK_d = holdK_q;
      code_d = code_q;
      if (!running) begin
         // comma preamble, fabric input is not looked at
         eA = encode(COMMA_BYTE, 1'b1, rd_q);
         eB = encode(COMMA_BYTE, 1'b1, eA[LANE_W]);
         code_d = {eB[LANE_W-1:0], eA[LANE_W-1:0]};
         // double width rounds the preamble up to whole output words
         rd_d = dbl ? eB[LANE_W] : eA[LANE_W];
         syncCnt_d = (dbl && syncCnt_q != 2'h2) ? syncCnt_q + 2'h2 : syncCnt_q + 2'h1;
         if (syncCnt_d > SYNC_GROUPS) begin
            syncCnt_d = SYNC_GROUPS;
         end
         phase_d = 1'b0;
      end else begin
         if (!phase_q) begin
            // first half straight from the fabric, keep the second half
            sA = laneIn[0];
            kA = txDataK[0];
            sB = laneIn[1];
            kB = txDataK[1];
            hold_d[0] = dbl ? laneIn[2] : laneIn[1];
            hold_d[1] = laneIn[3];
            holdK_d = dbl ? txDataK[3:2] : {1'b0, txDataK[1]};
         end else begin
            sA = hold_q[0];
            kA = holdK_q[0];
            sB = hold_q[1];
            kB = holdK_q[1];
         end
         phase_d = !phase_q;
         if (encOn) begin
            eA = encode(sA[BYTE_W-1:0], kA, rd_q);
            eB = encode(sB[BYTE_W-1:0], kB, eA[LANE_W]);
            code_d = dbl ? {eB[LANE_W-1:0], eA[LANE_W-1:0]} : {10'h000, eA[LANE_W-1:0]};
            rd_d = dbl ? eB[LANE_W] : eA[LANE_W];
         end else if (dbl) begin
            code_d = wide10 ? {sB, sA}
                            : {4'h0, sB[BYTE_W-1:0], sA[BYTE_W-1:0]};
         end else begin
            code_d = {10'h000, sA};
         end
      end
      // word is taken at the edge ending a cycle that starts a new pair
      ready_d = (syncCnt_d == SYNC_GROUPS || !encOn) && !phase_d;
   end

   // datapath registers, cleared and parked on the comma by reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phase_q <= 1'b0;
         ready_q <= 1'b0;
         rd_q <= 1'b0;
         syncCnt_q <= 2'h0;
         hold_q[0] <= '0;
         hold_q[1] <= '0;
         holdK_q <= '0;
         code_q <= {COMMA_NEG, COMMA_NEG};
      end else begin
         phase_q <= phase_d;
         ready_q <= ready_d;
         rd_q <= rd_d;
         syncCnt_q <= syncCnt_d;
         hold_q <= hold_d;
         holdK_q <= holdK_d;
         code_q <= code_d;
      end
   end

   assign txReady = ready_q;
   assign txCode = code_q;

   // axi4-lite slave state
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;

   // address and data are taken together, one write and one read in flight
   always_comb begin
      logic wTake;
      logic rTake;
      wTake = awvalid && wvalid && !awready_q && !bvalid_q;
      rTake = arvalid && !arready_q && !rvalid_q;
      awready_d = wTake;
      wready_d = wTake;
      ctrl_d = ctrl_q;
      bvalid_d = bvalid_q && !bready;
      bresp_d = bresp_q;
      arready_d = rTake;
      rvalid_d = rvalid_q && !rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (wTake) begin
         bvalid_d = 1'b1;
         bresp_d = RESP_SLVERR;
         if (awaddr == CTRL_ADDR) begin
            bresp_d = RESP_OKAY;
            if (wstrb[0]) begin
               ctrl_d = wdata[CTRL_W-1:0];
            end
         end else if (awaddr == STATUS_ADDR) begin
            bresp_d = RESP_OKAY; // status ignores writes
         end
      end
      if (rTake) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         if (araddr == CTRL_ADDR) begin
            rdata_d[CTRL_W-1:0] = ctrl_q;
         end else if (araddr == STATUS_ADDR) begin
            rdata_d[STAT_PHASE_BIT] = phase_q;
            rdata_d[STAT_RUN_BIT] = running;
            rdata_d[STAT_RD_BIT] = rd_q;
            rdata_d[STAT_CNT_LSB +: 2] = syncCnt_q;
         end else begin
            rresp_d = RESP_SLVERR;
         end
      end
   end

   // register bus flops
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q <= CTRL_RESET;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
endmodule

// ==== tx_byte_serializer_8b10b_encoder_bench.sv ====
// random stream and register bench for the transmit encoder
`timescale 1ns/1ns
module tx_byte_serializer_8b10b_encoder_bench;
   import tx_serenc_pkg::*;
   logic clk = 0, resetn = 0, pos = 0, run = 0, took = 0, took2 = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic txReady, awready, wready, bvalid, arready, rvalid;
   logic [39:0] txData, w, w2;
   logic [3:0] txDataK, k, k2, mode = 4'hc, awaddr = 0, araddr = 0, wstrb = 0;
   logic [19:0] txCode;
   logic [31:0] wdata = 0, rdata, v;
   logic [1:0] bresp, rresp, r;
   int err_total = 0, comparisons = 0, seed;
   logic [3:0] modes [9] = '{4'hc, 4'hd, 4'h2, 4'h3, 4'h6, 4'ha, 4'h0, 4'h1, 4'hc};
   initial forever #50 clk = ~clk;
   tx_fabric_src tx_fabric_src_inst (.clk, .mode, .txData, .txDataK);
   tx_byte_serializer_8b10b_encoder tx_byte_serializer_8b10b_encoder_inst (.clk, .resetn,
      .txData, .txDataK, .txReady, .txCode, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic results;
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic hang;
      err_total++;
      results;
   endtask
   // only the three byte values the source sends are modelled
   function automatic logic [9:0] enc(input logic [7:0] b, input logic q);
      if (q) begin
         pos = ~pos;
         return pos ? COMMA_NEG : ~COMMA_NEG;
      end
      return (b == 8'hb5) ? 10'h155 : 10'h2aa;
   endfunction
   function automatic logic [19:0] expw(input logic [39:0] x, input logic [3:0] q, input bit h);
      if (!(mode[2] && mode[3])) begin
         // raw halves, 10-bit lanes or bytes packed low
         if (mode[1]) return mode[0] ? x[20*h+:20] : {10'h0, x[10*h+:10]};
         return mode[0] ? {4'h0, x[16*h+:16]} : {12'h0, x[8*h+:8]};
      end
      if (!mode[0]) return {10'h0, enc(x[8*h+:8], q[h])};
      return {enc(x[16*h+8+:8], q[2*h+1]), enc(x[16*h+:8], q[2*h])};
   endfunction
   // halves of a taken word leave on the two following cycles
   always @(posedge clk) begin
      took <= txReady && run;
      took2 <= took;
      w <= txData;
      k <= txDataK;
      w2 <= w;
      k2 <= k;
   end
   always @(negedge clk) begin
      if (took) chk(txCode, expw(w, k, 0));
      if (took2) chk(txCode, expw(w2, k2, 1));
   end
   // bready raised a cycle late so a held response is seen too
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (bvalid && bready) break;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (n > 0) bready <= 1;
         if (n == 39) hang;
      end
      r = bresp;
      bready <= 0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (rvalid && rready) break;
         if (arready) arvalid <= 0;
         if (n > 0) rready <= 1;
         if (n == 39) hang;
      end
      v = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task automatic rst;
      @(posedge clk);
      resetn <= 0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(txCode, {2{COMMA_NEG}});
      chk(txReady, 0);
      @(posedge clk);
      resetn <= 1;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      hang;
   end
   initial begin
      seed = $urandom(20);
      foreach (modes[i]) begin
         // the halves of the last taken word are checked under the old mode first
         run <= 0;
         repeat (2) @(posedge clk);
         mode <= modes[i];
         rst;
         if (modes[i] == 4'hc) begin
            // three commas leave the disparity positive
            pos = 1;
            run <= 1;
         end else begin
            repeat (6) @(posedge clk);
            wr(CTRL_ADDR, 32'(modes[i]), 4'h1);
            chk(r, RESP_OKAY);
            repeat (4) @(posedge clk);
            run <= 1;
         end
         repeat (60) @(posedge clk);
         if (i == 0) begin
            rdr(STATUS_ADDR);
            chk({v[5:4], v[1]}, 3'h7);
            rdr(4'h8);
            chk(r, RESP_SLVERR);
            wr(CTRL_ADDR, 32'h0, 4'h0);
            chk(r, RESP_OKAY);
            wr(4'h8, 32'h0, 4'h1);
            chk(r, RESP_SLVERR);
         end
         rdr(CTRL_ADDR);
         chk(v, 32'(modes[i]));
      end
      results;
   end
endmodule

// ==== tx_fabric_src.sv ====
// fabric source model feeding transmit words
`timescale 1ns/1ns
module tx_fabric_src
   import tx_serenc_pkg::*;
(
   input wire logic clk,
   input wire logic [3:0] mode,
   output logic [39:0] txData,
   output logic [3:0] txDataK
);
   int s;
   logic [39:0] d;
   logic [3:0] kk;
   initial begin
      txData = '0;
      txDataK = '0;
   end
   // new word every cycle: the source ignores txReady, so one is always ready whenever the encoder takes one
   always @(posedge clk) begin
      d = {8'($urandom), $urandom};
      kk = 4'($urandom);
      if (mode[2] && mode[3]) begin
         d = '0;
         for (int i = 0; i < 4; i++) begin
            // commas only in single width, keeping double width disparity free
            s = mode[0] ? 1 + $urandom_range(1) : $urandom_range(2);
            d[8*i+:8] = (s == 0) ? COMMA_BYTE : (s == 1) ? 8'hb5 : 8'h4a;
            kk[i] = (s == 0);
         end
      end
      txData <= d;
      txDataK <= kk;
   end
endmodule

// ==== tx_serenc_chk.sv ====
// port assertions for the transmit serializer and encoder
`timescale 1ns/1ns
module tx_serenc_chk
   import tx_serenc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic txReady,
   input wire logic [19:0] txCode,
   input wire logic awvalid,
   input wire logic wvalid,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // lane 0 sync commas, columns alternating from negative
   sequence commas;
      txCode[9:0] == COMMA_NEG ##1 txCode[9:0] == ~COMMA_NEG ##1 txCode[9:0] == COMMA_NEG;
   endsequence
   // fabric held off for the whole preamble
   sequence hold_off;
      !txReady [*3] ##1 txReady;
   endsequence
   // reset rules must hold while reset is low, so no disable there
   a_reset_comma: assert property (disable iff (1'b0) !resetn |=> txCode == {2{COMMA_NEG}})
      else $error("output is not the negative comma in reset");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !txReady && !bvalid)
      else $error("ready or response raised in reset");
   a_sync_commas: assert property ($rose(resetn) |=> commas)
      else $error("sync preamble wrong");
   a_ready_delay: assert property ($rose(resetn) |-> hold_off)
      else $error("first word not taken after third comma");
   a_ready_alternates: assert property (txReady |=> !txReady)
      else $error("two words taken in back to back cycles");
   a_write_answer: assert property (awvalid && wvalid && !awready && !bvalid |=> awready && wready && bvalid)
      else $error("write not answered in one cycle");
   a_read_answer: assert property (arvalid && !arready && !rvalid |=> arready && rvalid)
      else $error("read not answered in one cycle");
   a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
endmodule
bind tx_byte_serializer_8b10b_encoder tx_serenc_chk tx_serenc_chk_inst (.clk, .resetn, .txReady,
   .txCode, .awvalid, .wvalid, .awready, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
   .rvalid, .rready, .rdata);

// ==== tx_serenc_pkg.sv ====
// constants shared by the transmit byte serializer and line encoder
package tx_serenc_pkg;
   // register map, byte addresses on the axi4-lite port
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam int ADDR_W = 4;
   // control register fields
   localparam int CTRL_DOUBLE_BIT = 0;
   localparam int CTRL_WIDE10_BIT = 1;
   localparam int CTRL_ENC_BIT = 2;
   localparam int CTRL_PCIE_BIT = 3;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RESET = 4'hc;
   // status register fields
   localparam int STAT_PHASE_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam int STAT_RD_BIT = 2;
   localparam int STAT_CNT_LSB = 4;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // line code constants
   localparam logic [7:0] COMMA_BYTE = 8'hbc;
   localparam logic [4:0] K28_X = 5'h1c;
   localparam logic [9:0] COMMA_NEG = 10'h17c;
   localparam logic [1:0] SYNC_GROUPS = 2'h3;
   localparam int LANE_W = 10;
   localparam int BYTE_W = 8;
endpackage
